/* File: logic/mfq_pkg.sv */
// Purpose: Constants and carrier types for the MAC FIFO status and receive descriptor queue block.
// Assumes: AHB-Lite register access with 32-bit data, one aligned word per register.
// Notes: Field positions, offsets and the accelerator, receive enable and mask reset values are named here; thresholds and status reset to zero in mfq_regs.
package mfq_pkg;

	localparam int DATA_W = 32;

	// Register byte addresses.
	localparam logic [31:0] OFF_RX_FIFO  = 32'h400f0200;
	localparam logic [31:0] OFF_TX_FIFO  = 32'h400f0204;
	localparam logic [31:0] OFF_ACCEL    = 32'h400f0208;
	localparam logic [31:0] OFF_RX_ENA   = 32'h400f0220;
	localparam logic [31:0] OFF_RX_THR0  = 32'h400f0240;
	localparam logic [31:0] OFF_RX_THR1  = 32'h400f0244;
	localparam logic [31:0] OFF_TX_THR   = 32'h400f0248;
	localparam logic [31:0] OFF_IRQ_STAT = 32'h400f024c;
	localparam logic [31:0] OFF_IRQ_MASK = 32'h400f0250;
	localparam logic [31:0] OFF_BUFQ     = 32'h400f1100;

	// Receive FIFO status layout.
	localparam int RXF_FULL_BIT = 31;
	localparam int RXF_EMP_BIT  = 30;
	localparam int RXF_REQ_BIT  = 29;
	localparam int RXF_CNT_LSB  = 17;
	localparam int RX_CNT_W     = 12;

	// Transmit FIFO status layout.
	localparam int TXF_FULL_BIT = 31;
	localparam int TXF_EMP_BIT  = 30;
	localparam int TXF_FRM_LSB  = 24;
	localparam int TX_FRM_W     = 3;

	// Accelerator control and receive enable layout.
	localparam int ACC_RXCK_OFF_BIT = 2;
	localparam int ACC_TX_EN_BIT    = 1;
	localparam int ACC_RX_EN_BIT    = 0;
	localparam int ENA_BIT          = 0;

	// Descriptor read layout.
	localparam int BQ_QUEUE_NOT_EMPTY_BIT = 31;
	localparam int BQ_VALID_BIT = 28;
	localparam int BQ_WORD_LSB  = 16;
	localparam int BQ_ADDR_LSB  = 0;
	localparam int BQ_WORD_W    = 12;
	localparam int BQ_ADDR_W    = 16;
	localparam int QUEUE_DEPTH  = 64;

	// Threshold register layout.
	localparam int THR_LO_LSB     = 0;
	localparam int THR_HI_LSB     = 16;
	localparam int TX_FULL_THR_W  = 2;
	localparam int TX_EMP_THR_W   = 3;
	localparam int TX_FULL_THR_LSB = 0;
	localparam int TX_EMP_THR_LSB  = 4;

	// Interrupt status and mask layout.
	localparam int IRQ_PUSH  = 0;
	localparam int IRQ_OVF   = 1;
	localparam int IRQ_RXREQ = 2;
	localparam int IRQ_TXEMP = 3;
	localparam int IRQ_W     = 4;

	// Reset values.
	localparam logic             RST_RXCK_OFF = 1'b0;
	localparam logic             RST_TX_EN    = 1'b0;
	localparam logic             RST_RX_EN    = 1'b0;
	localparam logic             RST_RX_ENA   = 1'b1;
	localparam logic [IRQ_W-1:0] RST_MASK     = 4'h0;

	// Bus encodings.
	localparam logic       HRESP_OKAY  = 1'b0;
	localparam int         HTRANS_BIT  = 1;

	typedef struct packed {
		logic                 valid;
		logic [BQ_WORD_W-1:0] words;
		logic [BQ_ADDR_W-1:0] addr;
	} mfq_desc_t;

	typedef struct packed {
		logic rx_checksum_off;
		logic tx_accel_enable;
		logic rx_accel_enable;
	} mfq_accel_t;

	typedef struct packed {
		logic [RX_CNT_W-1:0] full;
		logic [RX_CNT_W-1:0] empty;
		logic [RX_CNT_W-1:0] request;
	} mfq_rx_thr_t;

	typedef struct packed {
		logic [TX_FULL_THR_W-1:0] full;
		logic [TX_EMP_THR_W-1:0]  empty;
	} mfq_tx_thr_t;

endpackage

/* File: logic/mfq_regs.sv */
// Purpose: MAC FIFO status, accelerator control, receive enable and receive descriptor queue registers.
// Assumes: One clock; FIFO levels and descriptor pushes arrive synchronous to clock_in; zero-wait AHB-Lite slave.
// Notes: Queue depth must be a power of two so the pointers wrap on their own.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module mfq_regs #(
	parameter int RX_DEPTH = 2048,
	parameter int TX_DEPTH = 2048,
	parameter int TX_CNT_W = 12,
	parameter int Q_DEPTH  = mfq_pkg::QUEUE_DEPTH
) (
	input  wire logic                                clock_in,
	input  wire logic                                resetn_in,
	input  wire logic                                hsel_in,
	input  wire logic [31:0]                         haddr_in,
	input  wire logic [1:0]                          htrans_in,
	input  wire logic                                hwrite_in,
	input  wire logic [2:0]                          hsize_in,
	input  wire logic [31:0]                         hwdata_in,
	input  wire logic                                hready_in,
	output logic                                     hreadyout_out,
	output logic                                     hresp_out,
	output logic [31:0]                              hrdata_out,
	input  wire logic [mfq_pkg::RX_CNT_W-1:0]        rx_fifo_words_in,
	input  wire logic [TX_CNT_W-1:0]                 tx_fifo_words_in,
	input  wire logic [mfq_pkg::TX_FRM_W-1:0]        tx_result_frame_count_in,
	input  wire logic                                desc_push_in,
	input  wire mfq_pkg::mfq_desc_t                  desc_in,
	output logic                                     rx_nearly_full_flag_out,
	output logic                                     rx_nearly_empty_flag_out,
	output logic                                     rx_request_flag_out,
	output logic                                     tx_nearly_full_flag_out,
	output logic                                     tx_nearly_empty_flag_out,
	output mfq_pkg::mfq_accel_t                      accel_out,
	output logic                                     rx_mac_enable_out,
	output logic                                     queue_full_out,
	output logic                                     rx_dma_done_irq_out,
	output logic                                     irq_out
);

	localparam int QA_W = $clog2(Q_DEPTH);
	localparam logic [mfq_pkg::RX_CNT_W:0] RX_DEPTH_V = (mfq_pkg::RX_CNT_W+1)'(RX_DEPTH);
	localparam logic [TX_CNT_W:0]          TX_DEPTH_V = (TX_CNT_W+1)'(TX_DEPTH);
	localparam logic [QA_W:0]              Q_DEPTH_V  = (QA_W+1)'(Q_DEPTH);

	// Bus phase state.
	logic                       wr_pend_q, wr_pend_d;
	logic [31:0]                wr_addr_q, wr_addr_d;
	logic [31:0]                hrdata_q, hrdata_d;

	// Software state.
	mfq_pkg::mfq_accel_t        accel_q, accel_d;
	logic                       ena_q, ena_d;
	mfq_pkg::mfq_rx_thr_t       rx_thr_q, rx_thr_d;
	mfq_pkg::mfq_tx_thr_t       tx_thr_q, tx_thr_d;
	logic [mfq_pkg::IRQ_W-1:0]  mask_q, mask_d;
	logic [mfq_pkg::IRQ_W-1:0]  stat_q, stat_d;
	logic [mfq_pkg::IRQ_W-1:0]  ev;
	logic                       stat_clr;

	// Queue state.
	mfq_pkg::mfq_desc_t         qmem [Q_DEPTH];
	logic [QA_W-1:0]            wptr_q, wptr_d, rptr_q, rptr_d;
	logic [QA_W:0]              cnt_q, cnt_d;
	logic                       push_ok, pop;

	// Live flags and their registered copies.
	logic [mfq_pkg::RX_CNT_W:0] rx_free;
	logic [TX_CNT_W:0]          tx_free;
	logic                       rx_full_f, rx_emp_f, rx_req_f, tx_full_f, tx_emp_f;
	logic                       rx_full_q, rx_emp_q, rx_req_q, tx_full_q, tx_emp_q;
	logic                       irq_d, irq_q, done_d, done_q, qfull_d, qfull_q;
	logic                       armed_q, armed_d;

	logic                       acc_sel, rd;

	// Threshold flags follow the live occupancy on every cycle.
	always_comb begin
		rx_free   = RX_DEPTH_V - {1'b0, rx_fifo_words_in};
		tx_free   = TX_DEPTH_V - {1'b0, tx_fifo_words_in};
		rx_full_f = rx_free <= {1'b0, rx_thr_q.full};
		rx_emp_f  = rx_fifo_words_in <= rx_thr_q.empty;
		rx_req_f  = rx_fifo_words_in > rx_thr_q.request;
		tx_full_f = tx_free < (TX_CNT_W+1)'(tx_thr_q.full);
		tx_emp_f  = tx_fifo_words_in <= TX_CNT_W'(tx_thr_q.empty);
	end

	// Address phase decode and queue movement.
	always_comb begin
		acc_sel = hsel_in & htrans_in[mfq_pkg::HTRANS_BIT] & hready_in;
		rd      = acc_sel & ~hwrite_in;
		pop     = rd && (haddr_in == mfq_pkg::OFF_BUFQ) && (cnt_q != '0);
		push_ok = desc_push_in && ((cnt_q != Q_DEPTH_V) || pop);
		wptr_d  = push_ok ? wptr_q + 1'b1 : wptr_q;
		rptr_d  = pop ? rptr_q + 1'b1 : rptr_q;
		cnt_d   = cnt_q + (QA_W+1)'(push_ok) - (QA_W+1)'(pop);
		stat_clr = rd && (haddr_in == mfq_pkg::OFF_IRQ_STAT);
		ev[mfq_pkg::IRQ_PUSH]  = push_ok;
		ev[mfq_pkg::IRQ_OVF]   = desc_push_in & ~push_ok;
		// Flag history is trusted from the second edge after reset only, so no false rise follows reset.
		armed_d = 1'b1;
		ev[mfq_pkg::IRQ_RXREQ] = rx_req_f & ~rx_req_q & armed_q;
		ev[mfq_pkg::IRQ_TXEMP] = tx_emp_f & ~tx_emp_q & armed_q;
	end

	// Sticky status: a new event wins over the read that clears it.
	for (genvar i = 0; i < mfq_pkg::IRQ_W; i++) begin : g_stat
		assign stat_d[i] = ev[i] | (stat_q[i] & ~stat_clr);
	end

	// Writes land in the data phase; reads see the value about to be stored.
	always_comb begin
		wr_pend_d = acc_sel & hwrite_in;
		wr_addr_d = haddr_in;
		accel_d   = accel_q;
		ena_d     = ena_q;
		rx_thr_d  = rx_thr_q;
		tx_thr_d  = tx_thr_q;
		mask_d    = mask_q;
		if (wr_pend_q) begin
			case (wr_addr_q)
				mfq_pkg::OFF_ACCEL: begin
					accel_d.rx_checksum_off = hwdata_in[mfq_pkg::ACC_RXCK_OFF_BIT];
					accel_d.tx_accel_enable = hwdata_in[mfq_pkg::ACC_TX_EN_BIT];
					accel_d.rx_accel_enable = hwdata_in[mfq_pkg::ACC_RX_EN_BIT];
				end
				mfq_pkg::OFF_RX_ENA: begin
					ena_d = hwdata_in[mfq_pkg::ENA_BIT];
				end
				mfq_pkg::OFF_RX_THR0: begin
					rx_thr_d.full  = hwdata_in[mfq_pkg::THR_LO_LSB +: mfq_pkg::RX_CNT_W];
					rx_thr_d.empty = hwdata_in[mfq_pkg::THR_HI_LSB +: mfq_pkg::RX_CNT_W];
				end
				mfq_pkg::OFF_RX_THR1: begin
					rx_thr_d.request = hwdata_in[mfq_pkg::THR_LO_LSB +: mfq_pkg::RX_CNT_W];
				end
				mfq_pkg::OFF_TX_THR: begin
					tx_thr_d.full  = hwdata_in[mfq_pkg::TX_FULL_THR_LSB +: mfq_pkg::TX_FULL_THR_W];
					tx_thr_d.empty = hwdata_in[mfq_pkg::TX_EMP_THR_LSB +: mfq_pkg::TX_EMP_THR_W];
				end
				mfq_pkg::OFF_IRQ_MASK: begin
					mask_d = hwdata_in[mfq_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is formed in the address phase and stands in the data phase.
	always_comb begin
		hrdata_d = '0;
		if (rd) begin
			case (haddr_in)
				mfq_pkg::OFF_RX_FIFO: begin
					hrdata_d[mfq_pkg::RXF_FULL_BIT] = rx_full_f;
					hrdata_d[mfq_pkg::RXF_EMP_BIT]  = rx_emp_f;
					hrdata_d[mfq_pkg::RXF_REQ_BIT]  = rx_req_f;
					hrdata_d[mfq_pkg::RXF_CNT_LSB +: mfq_pkg::RX_CNT_W] = rx_fifo_words_in;
				end
				mfq_pkg::OFF_TX_FIFO: begin
					hrdata_d[mfq_pkg::TXF_FULL_BIT] = tx_full_f;
					hrdata_d[mfq_pkg::TXF_EMP_BIT]  = tx_emp_f;
					hrdata_d[mfq_pkg::TXF_FRM_LSB +: mfq_pkg::TX_FRM_W] = tx_result_frame_count_in;
				end
				mfq_pkg::OFF_ACCEL: begin
					hrdata_d[mfq_pkg::ACC_RXCK_OFF_BIT] = accel_d.rx_checksum_off;
					hrdata_d[mfq_pkg::ACC_TX_EN_BIT]    = accel_d.tx_accel_enable;
					hrdata_d[mfq_pkg::ACC_RX_EN_BIT]    = accel_d.rx_accel_enable;
				end
				mfq_pkg::OFF_RX_ENA: begin
					hrdata_d[mfq_pkg::ENA_BIT] = ena_d;
				end
				mfq_pkg::OFF_RX_THR0: begin
					hrdata_d[mfq_pkg::THR_LO_LSB +: mfq_pkg::RX_CNT_W] = rx_thr_d.full;
					hrdata_d[mfq_pkg::THR_HI_LSB +: mfq_pkg::RX_CNT_W] = rx_thr_d.empty;
				end
				mfq_pkg::OFF_RX_THR1: begin
					hrdata_d[mfq_pkg::THR_LO_LSB +: mfq_pkg::RX_CNT_W] = rx_thr_d.request;
				end
				mfq_pkg::OFF_TX_THR: begin
					hrdata_d[mfq_pkg::TX_FULL_THR_LSB +: mfq_pkg::TX_FULL_THR_W] = tx_thr_d.full;
					hrdata_d[mfq_pkg::TX_EMP_THR_LSB +: mfq_pkg::TX_EMP_THR_W]   = tx_thr_d.empty;
				end
				mfq_pkg::OFF_IRQ_STAT: begin
					hrdata_d[mfq_pkg::IRQ_W-1:0] = stat_q;
				end
				mfq_pkg::OFF_IRQ_MASK: begin
					hrdata_d[mfq_pkg::IRQ_W-1:0] = mask_d;
				end
				mfq_pkg::OFF_BUFQ: begin
					if (cnt_q != '0) begin
						hrdata_d[mfq_pkg::BQ_QUEUE_NOT_EMPTY_BIT] = 1'b1;
						hrdata_d[mfq_pkg::BQ_VALID_BIT] = qmem[rptr_q].valid;
						hrdata_d[mfq_pkg::BQ_WORD_LSB +: mfq_pkg::BQ_WORD_W] = qmem[rptr_q].words;
						hrdata_d[mfq_pkg::BQ_ADDR_LSB +: mfq_pkg::BQ_ADDR_W] = qmem[rptr_q].addr;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Outputs driven from flip-flops.
	always_comb begin
		done_d  = cnt_d != '0;
		qfull_d = cnt_d == Q_DEPTH_V;
		irq_d   = |(stat_d & mask_d);
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q  <= '0;
			accel_q   <= '{rx_checksum_off: mfq_pkg::RST_RXCK_OFF, tx_accel_enable: mfq_pkg::RST_TX_EN,
			               rx_accel_enable: mfq_pkg::RST_RX_EN};
			ena_q     <= mfq_pkg::RST_RX_ENA;
			rx_thr_q  <= '0;
			tx_thr_q  <= '0;
			mask_q    <= mfq_pkg::RST_MASK;
			stat_q    <= '0;
			wptr_q    <= '0;
			rptr_q    <= '0;
			cnt_q     <= '0;
			rx_full_q <= 1'b0;
			rx_emp_q  <= 1'b0;
			rx_req_q  <= 1'b0;
			tx_full_q <= 1'b0;
			tx_emp_q  <= 1'b0;
			irq_q     <= 1'b0;
			done_q    <= 1'b0;
			qfull_q   <= 1'b0;
			armed_q   <= 1'b0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q  <= hrdata_d;
			accel_q   <= accel_d;
			ena_q     <= ena_d;
			rx_thr_q  <= rx_thr_d;
			tx_thr_q  <= tx_thr_d;
			mask_q    <= mask_d;
			stat_q    <= stat_d;
			wptr_q    <= wptr_d;
			rptr_q    <= rptr_d;
			cnt_q     <= cnt_d;
			rx_full_q <= rx_full_f;
			rx_emp_q  <= rx_emp_f;
			rx_req_q  <= rx_req_f;
			tx_full_q <= tx_full_f;
			tx_emp_q  <= tx_emp_f;
			irq_q     <= irq_d;
			done_q    <= done_d;
			qfull_q   <= qfull_d;
			armed_q   <= armed_d;
		end
	end

	// Descriptor storage has no reset; entries are only read once written.
	always_ff @(posedge clock_in) begin
		if (push_ok) begin
			qmem[wptr_q] <= desc_in;
		end
	end

	assign hreadyout_out            = 1'b1;
	assign hresp_out                = mfq_pkg::HRESP_OKAY;
	assign hrdata_out               = hrdata_q;
	assign rx_nearly_full_flag_out  = rx_full_q;
	assign rx_nearly_empty_flag_out = rx_emp_q;
	assign rx_request_flag_out      = rx_req_q;
	assign tx_nearly_full_flag_out  = tx_full_q;
	assign tx_nearly_empty_flag_out = tx_emp_q;
	assign accel_out                = accel_q;
	assign rx_mac_enable_out        = ena_q;
	assign queue_full_out           = qfull_q;
	assign rx_dma_done_irq_out      = done_q;
	assign irq_out                  = irq_q;

	// Checks.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	logic rd_rxf_q, rd_txf_q, rd_bq_q;
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_rxf_q <= 1'b0;
			rd_txf_q <= 1'b0;
			rd_bq_q  <= 1'b0;
		end else begin
			rd_rxf_q <= rd && (haddr_in == mfq_pkg::OFF_RX_FIFO);
			rd_txf_q <= rd && (haddr_in == mfq_pkg::OFF_TX_FIFO);
			rd_bq_q  <= rd && (haddr_in == mfq_pkg::OFF_BUFQ);
		end
	end

	rx_full_flag_a: assert property (
		##1 rx_nearly_full_flag_out == ($past(rx_free) <= {1'b0, $past(rx_thr_q.full)}))
		else $error("rx nearly-full flag wrong");
	rx_empty_flag_a: assert property (
		$rose(rx_fifo_words_in <= rx_thr_q.empty) |=> rx_nearly_empty_flag_out)
		else $error("rx nearly-empty flag missed");
	rx_req_flag_a: assert property (
		(rx_fifo_words_in > rx_thr_q.request) |=> rx_request_flag_out)
		else $error("rx request flag missed");
	rx_count_read_a: assert property (
		rd_rxf_q |-> hrdata_out[mfq_pkg::RXF_CNT_LSB +: mfq_pkg::RX_CNT_W] == $past(rx_fifo_words_in)
		&& hrdata_out[mfq_pkg::RXF_CNT_LSB-1:0] == '0)
		else $error("rx word count read wrong");
	tx_full_flag_a: assert property (
		##1 tx_nearly_full_flag_out == ($past(tx_free) < (TX_CNT_W+1)'($past(tx_thr_q.full))))
		else $error("tx nearly-full flag wrong");
	tx_empty_flag_a: assert property (
		rd_txf_q |-> hrdata_out[mfq_pkg::TXF_EMP_BIT]
		== ($past(tx_fifo_words_in) <= TX_CNT_W'($past(tx_thr_q.empty))))
		else $error("tx nearly-empty read wrong");
	tx_frames_read_a: assert property (
		rd_txf_q |-> hrdata_out[mfq_pkg::TXF_FRM_LSB +: mfq_pkg::TX_FRM_W] == $past(tx_result_frame_count_in))
		else $error("tx frame count read wrong");
	accel_write_a: assert property (
		wr_pend_q && wr_addr_q == mfq_pkg::OFF_ACCEL |=>
		accel_out == $past(hwdata_in[mfq_pkg::ACC_RXCK_OFF_BIT:mfq_pkg::ACC_RX_EN_BIT]))
		else $error("accelerator control not written");
	rx_enable_a: assert property (
		wr_pend_q && wr_addr_q == mfq_pkg::OFF_RX_ENA |=>
		rx_mac_enable_out == $past(hwdata_in[mfq_pkg::ENA_BIT]))
		else $error("receive enable not written");
	queue_push_a: assert property (
		desc_push_in && !qfull_q && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("descriptor not queued");
	queue_drop_a: assert property (
		desc_push_in && qfull_q && !pop |=> cnt_q == $past(cnt_q) && stat_q[mfq_pkg::IRQ_OVF])
		else $error("overflowing descriptor not dropped");
	queue_full_a: assert property (
		queue_full_out == (cnt_q == Q_DEPTH_V))
		else $error("queue full flag wrong");
	done_irq_level_a: assert property (
		##1 rx_dma_done_irq_out == ($past(cnt_d) != '0))
		else $error("completion interrupt level wrong");
	queue_pop_a: assert property (
		pop && !desc_push_in |=> cnt_q == $past(cnt_q) - 1'b1)
		else $error("descriptor not removed");
	desc_layout_a: assert property (
		rd_bq_q |-> hrdata_out[mfq_pkg::BQ_QUEUE_NOT_EMPTY_BIT] == ($past(cnt_q) != '0) && hrdata_out[30:29] == 2'h0)
		else $error("descriptor read layout wrong");
	reserved_zero_a: assert property (
		rd_bq_q && !hrdata_out[mfq_pkg::BQ_QUEUE_NOT_EMPTY_BIT] |-> hrdata_out == '0)
		else $error("empty descriptor read not zero");
	rx_empty_level_a: assert property (
		$past(resetn_in) |-> rx_nearly_empty_flag_out == ($past(rx_fifo_words_in) <= $past(rx_thr_q.empty)))
		else $error("rx nearly-empty flag level wrong");
	rx_req_clear_a: assert property (
		(rx_fifo_words_in <= rx_thr_q.request) |=> !rx_request_flag_out)
		else $error("rx request flag not cleared");
	tx_empty_level_a: assert property (
		$past(resetn_in) |-> tx_nearly_empty_flag_out
		== ($past(tx_fifo_words_in) <= TX_CNT_W'($past(tx_thr_q.empty))))
		else $error("tx nearly-empty flag wrong");
	irq_level_a: assert property (
		irq_out == |(stat_q & mask_q))
		else $error("interrupt level wrong");

	push_seen_c: cover property (push_ok ##1 pop);
	queue_full_c: cover property (qfull_q && desc_push_in);
	irq_seen_c: cover property ($rose(irq_out));
	drain_c: cover property ($fell(rx_dma_done_irq_out));
	stat_clear_c: cover property (stat_clr && stat_q != '0);

endmodule // mfq_regs

/* File: sim/mfq_far_model.sv */
// Purpose: Far-side model of the MAC FIFOs and the receive DMA that feed the status block.
// Assumes: The bench calls its tasks; every output changes just after a rising edge of clock_in.
// Notes: Outside a push cycle the descriptor lines show the inverse of the last value sent.
`timescale 1ns/100ps
module mfq_far_model (
	input  wire logic         clock_in,
	output logic [11:0]       rx_words_out,
	output logic [11:0]       tx_words_out,
	output logic [2:0]        frames_out,
	output logic              push_out,
	output mfq_pkg::mfq_desc_t desc_out
);
	initial begin
		rx_words_out = 12'h000;
		tx_words_out = 12'h000;
		frames_out   = 3'h0;
		push_out     = 1'b0;
		desc_out     = '0;
	end

	// Levels are held two extra cycles so registered flags have settled before a read.
	task automatic set_fifo(input logic [11:0] rx, input logic [11:0] tx, input logic [2:0] fr);
		@(posedge clock_in);
		rx_words_out <= rx;
		tx_words_out <= tx;
		frames_out   <= fr;
		repeat (2) @(posedge clock_in);
	endtask

	// One finished frame: a single-cycle push with its descriptor.
	task automatic push(input mfq_pkg::mfq_desc_t d);
		@(posedge clock_in);
		push_out <= 1'b1;
		desc_out <= d;
		@(posedge clock_in);
		push_out <= 1'b0;
		desc_out <= ~d;
	endtask
endmodule // mfq_far_model

/* File: sim/tb_mfq_regs.sv */
// Purpose: Self-checking bench for the MAC FIFO status and descriptor queue registers.
// Assumes: AHB-Lite single word transfers; hready is the block's own hreadyout.
// Notes: Expected values are built from the thresholds and descriptors that the bench chooses.
`timescale 1ns/100ps
module tb_mfq_regs;
	logic               clock_in;
	logic               resetn_in;
	logic               hsel;
	logic [31:0]        haddr;
	logic [1:0]         htrans;
	logic               hwrite;
	logic [31:0]        hwdata;
	logic               hready;
	logic               hresp;
	logic [31:0]        hrdata;
	logic [11:0]        rx_words;
	logic [11:0]        tx_words;
	logic [2:0]         frames;
	logic               push;
	mfq_pkg::mfq_desc_t desc;
	mfq_pkg::mfq_accel_t accel;
	logic               f_rx_nearly_full_flag, f_rx_nearly_empty_flag, f_rreq, f_tx_nearly_full_flag, f_temp, rx_ena, q_full, dma_irq, irq;
	logic [31:0]        v;
	logic [2:0]         er;
	logic [1:0]         et;
	int                 err_count;
	int                 num_checks;
	logic [11:0]        rxw [6] = '{12'd10, 12'd11, 12'd50, 12'd51, 12'd1948, 12'd1947};
	logic [11:0]        txw [6] = '{12'd3, 12'd4, 12'd2046, 12'd2047, 12'd0, 12'd1};

	mfq_far_model far (.clock_in(clock_in), .rx_words_out(rx_words), .tx_words_out(tx_words),
		.frames_out(frames), .push_out(push), .desc_out(desc));

	mfq_regs dut (.clock_in(clock_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
		.hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .rx_fifo_words_in(rx_words),
		.tx_fifo_words_in(tx_words), .tx_result_frame_count_in(frames), .desc_push_in(push), .desc_in(desc),
		.rx_nearly_full_flag_out(f_rx_nearly_full_flag), .rx_nearly_empty_flag_out(f_rx_nearly_empty_flag), .rx_request_flag_out(f_rreq),
		.tx_nearly_full_flag_out(f_tx_nearly_full_flag), .tx_nearly_empty_flag_out(f_temp), .accel_out(accel),
		.rx_mac_enable_out(rx_ena), .queue_full_out(q_full), .rx_dma_done_irq_out(dma_irq), .irq_out(irq));

	function automatic mfq_pkg::mfq_desc_t mk(input int i);
		return '{valid: i[0], words: 12'(i + 3), addr: 16'(i * 5 + 1)};
	endfunction

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Address phase held until hready, then data phase held until hready; read data taken there.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clock_in);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock_in); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask

	task automatic rc(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	initial begin
		repeat (5000) @(posedge clock_in);
		err_count++;
		stop_test();
	end

	initial begin
		resetn_in  = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hwdata     = 32'h0;
		err_count  = 0;
		num_checks = 0;
		repeat (4) @(posedge clock_in);
		resetn_in <= 1'b1;
		rc(mfq_pkg::OFF_ACCEL, 32'h0);
		rc(mfq_pkg::OFF_RX_ENA, 32'h1);
		rc(mfq_pkg::OFF_BUFQ, 32'h0);
		rc(mfq_pkg::OFF_IRQ_MASK, 32'h0);
		for (int k = 0; k < 3; k++) begin
			wr(mfq_pkg::OFF_ACCEL, 32'h1 << k);
			rc(mfq_pkg::OFF_ACCEL, 32'h1 << k);
			chk({29'h0, accel}, 32'h1 << k);
		end
		wr(mfq_pkg::OFF_ACCEL, 32'hffffffff);
		rc(mfq_pkg::OFF_ACCEL, 32'h7);
		wr(mfq_pkg::OFF_RX_ENA, 32'hfffffffe);
		rc(mfq_pkg::OFF_RX_ENA, 32'h0);
		chk({31'h0, rx_ena}, 32'h0);
		wr(mfq_pkg::OFF_RX_ENA, 32'hffffffff);
		rc(mfq_pkg::OFF_RX_ENA, 32'h1);
		chk({31'h0, rx_ena}, 32'h1);
		wr(32'h400f0210, 32'hffffffff);
		rc(32'h400f0210, 32'h0);
		// Thresholds: rx full 100, rx empty 10, rx request 50, tx full 2, tx empty 3.
		wr(mfq_pkg::OFF_RX_THR0, 32'h000a0064);
		wr(mfq_pkg::OFF_RX_THR1, 32'h00000032);
		wr(mfq_pkg::OFF_TX_THR, 32'h00000032);
		for (int i = 0; i < 6; i++) begin
			far.set_fifo(rxw[i], txw[i], 3'(i + 2));
			er = {2048 - int'(rxw[i]) <= 100, rxw[i] <= 12'd10, rxw[i] > 12'd50};
			et = {2048 - int'(txw[i]) < 2, txw[i] <= 12'd3};
			rc(mfq_pkg::OFF_RX_FIFO, {er, rxw[i], 17'h0});
			rc(mfq_pkg::OFF_TX_FIFO, {et, 3'h0, 3'(i + 2), 24'h0});
			chk({27'h0, f_rx_nearly_full_flag, f_rx_nearly_empty_flag, f_rreq, f_tx_nearly_full_flag, f_temp}, {27'h0, er, et});
		end
		// The request flag rose while masked: status holds it, the interrupt stays low.
		chk({31'h0, irq}, 32'h0);
		rd(mfq_pkg::OFF_IRQ_STAT, v);
		chk(v & 32'h4, 32'h4);
		rc(mfq_pkg::OFF_IRQ_STAT, 32'h0);
		wr(mfq_pkg::OFF_IRQ_MASK, 32'h3);
		for (int i = 0; i < 65; i++) far.push(mk(i));
		chk({30'h0, q_full, dma_irq}, 32'h3);
		chk({31'h0, irq}, 32'h1);
		rc(mfq_pkg::OFF_IRQ_STAT, 32'h3);
		repeat (2) @(posedge clock_in);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 64; i++) begin
			if (i == 63) chk({31'h0, dma_irq}, 32'h1);
			rd(mfq_pkg::OFF_BUFQ, v);
			chk(v, {1'b1, 2'h0, mk(i)});
			chk({v[15:0], 11'h0} + 32'h08000000, 32'(32'h08000000 + (i * 5 + 1) * 2048));
			chk(32'(v[27:16]) - 32'd2, 32'(i + 1));
		end
		repeat (2) @(posedge clock_in);
		chk({30'h0, q_full, dma_irq}, 32'h0);
		rc(mfq_pkg::OFF_BUFQ, 32'h0);
		stop_test();
	end
endmodule // tb_mfq_regs
